// File: bench/prc_far_side.sv
`timescale 1ns/1ns
`default_nettype none

module prc_far_side (
  input wire logic clk_sys, // bus clock
  input wire logic [31:0] stim, // next far-side levels
  output logic [7:0] pwm_out = 8'h00, // pwm channel levels
  output logic [7:0] pwm_enabled = 8'h00, // pwm channel enables
  output logic [3:0] timer_unit_oc = 4'h0, // timer compare levels
  output logic [3:0] timer_unit_oc_en = 4'h0, // timer compare enables
  output logic [1:0] high_side_port_bits = 2'h0, // high-side port bits
  output logic [1:0] low_side_port_bits = 2'h0 // low-side port bits
);
  // registered sources change just after an edge, never mid-cycle
  always @(posedge clk_sys) begin
    pwm_out <= stim[7:0];
    pwm_enabled <= stim[15:8];
    timer_unit_oc <= stim[19:16];
    timer_unit_oc_en <= stim[23:20];
    high_side_port_bits <= stim[25:24];
    low_side_port_bits <= stim[27:26];
  end
endmodule

`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "prc_params.svh"

module tb;
  import prc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic special_mode = 1'b0;
  logic oc_ev = 1'b0;
  logic [31:0] stim = 32'h0;
  logic [31:0] seed = 32'hb8db034c;
  logic [3:0] t_on = 4'h0;
  logic [5:0] p_in = 6'h30;
  logic [5:0] p_out = 6'h00;
  prc_apb_req_t req = '0;
  prc_apb_rsp_t rsp;
  prc_drv_pins_t drv;
  logic [7:0] pwm, pe;
  logic [3:0] oc, oe, t_pd, t_pu;
  logic [1:0] hs, ls;
  logic [5:0] p_pd, p_pu, p_red;
  logic irq;
  logic [31:0] rd;
  logic [7:0] code;
  int errors = 0;
  int checks_done = 0;

  initial forever #2 clk_sys = ~clk_sys;

  prc_far_side i_prc_far_side (.clk_sys(clk_sys), .stim(stim), .pwm_out(pwm),
    .pwm_enabled(pe), .timer_unit_oc(oc), .timer_unit_oc_en(oe),
    .high_side_port_bits(hs), .low_side_port_bits(ls));

  prc_port_routing i_prc_port_routing (.clk_sys(clk_sys), .rst(rst),
    .special_mode(special_mode), .apb_req(req), .apb_rsp(rsp),
    .high_side_port_bits(hs), .low_side_port_bits(ls), .pwm_out(pwm),
    .pwm_enabled(pe), .timer_unit_oc(oc), .timer_unit_oc_en(oe), .drv_pins(drv),
    .port_t_pull_on(t_on), .port_t_pulldown(t_pd), .port_t_pullup(t_pu),
    .port_p_in(p_in), .port_p_is_output(p_out), .port_p_pulldown(p_pd),
    .port_p_pullup(p_pu), .port_p_reduced(p_red), .overcurrent_event(oc_ev),
    .irq(irq));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // a routed source that is not enabled falls back to the port bit
  function automatic logic pick(input logic [1:0] s, input logic p, a, ae, b, be, c, ce);
    case (s)
      2'h3: return ae ? a : p;
      2'h2: return be ? b : p;
      2'h1: return ce ? c : p;
      default: return p;
    endcase
  endfunction

  function automatic logic [3:0] exp_drv(input logic [7:0] r);
    return {pick(r[7:6], hs[1], pwm[1], pe[1], pwm[4], pe[4], oc[3], oe[3]),
      pick(r[5:4], hs[0], pwm[3], pe[3], pwm[3], pe[3], oc[2], oe[2]),
      pick(r[3:2], ls[1], pwm[7], pe[7], pwm[7], pe[7], oc[1], oe[1]),
      pick(r[1:0], ls[0], pwm[5], pe[5], pwm[6], pe[6], oc[0], oe[0])};
  endfunction

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    // only the watchdog ends a slave that never answers
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    chk(rsp.pslverr, 1'b0);
    req <= '0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge clk_sys);
    chk(irq, e);
  endtask

  task automatic new_stim;
    seed = lfsr(seed);
    @(posedge clk_sys);
    stim <= seed;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic finish_test;
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    new_stim;
    chk(drv, exp_drv(8'h00));
    rd_chk(`PRC_ADDR_ROUTING, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, `PRC_ADDR_ROUTING, 32'h5a);
    rd_chk(`PRC_ADDR_ROUTING, 32'h5a);
    apb(1'b1, `PRC_ADDR_ROUTING, 32'ha5);
    rd_chk(`PRC_ADDR_ROUTING, 32'h5a);
    apb(1'b1, 12'h01c, 32'hff);
    rd_chk(12'h01c, 32'h0);
    @(posedge clk_sys);
    special_mode <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      code = (i < 4) ? {4{i[1:0]}} : seed[15:8];
      apb(1'b1, `PRC_ADDR_ROUTING, {24'h0, code});
      rd_chk(`PRC_ADDR_ROUTING, {24'h0, code});
      repeat (4) begin
        new_stim;
        chk(drv, exp_drv(code));
      end
    end
    // mid-run reset reopens the one-shot routing write
    @(posedge clk_sys);
    rst <= 1'b1;
    special_mode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(`PRC_ADDR_ROUTING, 32'h0);
    apb(1'b1, `PRC_ADDR_ROUTING, 32'h3c);
    apb(1'b1, `PRC_ADDR_ROUTING, 32'hc3);
    rd_chk(`PRC_ADDR_ROUTING, 32'h3c);
    repeat (8) begin
      seed = lfsr(seed);
      apb(1'b1, `PRC_ADDR_T_POLARITY, {24'h0, seed[7:0]});
      apb(1'b1, `PRC_ADDR_P_PULL_EN, {24'h0, seed[15:8]});
      apb(1'b1, `PRC_ADDR_P_POLARITY, {24'h0, seed[23:16]});
      apb(1'b1, `PRC_ADDR_P_DRIVE, {24'h0, seed[31:24]});
      @(posedge clk_sys);
      t_on <= seed[3:0] ^ seed[11:8];
      p_out <= seed[5:0] ^ seed[29:24];
      @(negedge clk_sys);
      chk({t_pd, t_pu}, {t_on & seed[3:0], t_on & ~seed[3:0]});
      chk({p_pd, p_pu}, {seed[13:8] & ~p_out & seed[21:16],
        seed[13:8] & ~p_out & ~seed[21:16]});
      chk(p_red, seed[29:24] & p_out);
    end
    // pins 0-3 watch rising edges, pins 4-5 falling
    apb(1'b1, `PRC_ADDR_P_POLARITY, 32'h0f);
    apb(1'b1, `PRC_ADDR_P_IRQ_EN, 32'h3f);
    apb(1'b1, `PRC_ADDR_P_FLAGS, 32'hff);
    chk_irq(1'b0);
    @(posedge clk_sys);
    p_in <= 6'h0f;
    repeat (5) @(posedge clk_sys);
    rd_chk(`PRC_ADDR_P_FLAGS, 32'h3f);
    chk_irq(1'b1);
    apb(1'b1, `PRC_ADDR_P_FLAGS, 32'h00);
    rd_chk(`PRC_ADDR_P_FLAGS, 32'h3f);
    apb(1'b1, `PRC_ADDR_P_FLAGS, 32'hff);
    rd_chk(`PRC_ADDR_P_FLAGS, 32'h00);
    @(posedge clk_sys);
    p_in <= 6'h30;
    repeat (5) @(posedge clk_sys);
    rd_chk(`PRC_ADDR_P_FLAGS, 32'h00);
    @(posedge clk_sys);
    oc_ev <= 1'b1;
    @(posedge clk_sys);
    oc_ev <= 1'b0;
    rd_chk(`PRC_ADDR_P_FLAGS, 32'h80);
    chk_irq(1'b0);
    apb(1'b1, `PRC_ADDR_P_IRQ_EN, 32'h80);
    chk_irq(1'b1);
    apb(1'b1, `PRC_ADDR_P_FLAGS, 32'h80);
    chk_irq(1'b0);
    finish_test;
  end
endmodule

`default_nettype wire

// File: hw/prc_params.svh
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

// apb byte addresses
`define PRC_ADDR_ROUTING 12'h000
`define PRC_ADDR_T_POLARITY 12'h004
`define PRC_ADDR_P_DRIVE 12'h008
`define PRC_ADDR_P_PULL_EN 12'h00c
`define PRC_ADDR_P_FLAGS 12'h010
`define PRC_ADDR_P_POLARITY 12'h014
`define PRC_ADDR_P_IRQ_EN 12'h018

// routing field positions
`define PRC_HSB_LSB 6
`define PRC_HSA_LSB 4
`define PRC_LSB_LSB 2
`define PRC_LSA_LSB 0

// routing selector codes
`define PRC_SEL_PORT 2'h0
`define PRC_SEL_TIMER 2'h1
`define PRC_SEL_PWM_ALT 2'h2
`define PRC_SEL_PWM 2'h3

// flag register layout
`define PRC_OC_BIT 7
`define PRC_EDGE_MASK 8'h3f

// reset values
`define PRC_RST_ROUTING 8'h00
`define PRC_RST_ZERO 8'h00

`endif

// File: hw/prc_pkg.sv
package prc_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } prc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } prc_apb_rsp_t;

  typedef struct packed {
    logic [1:0] high_side_driver;
    logic [1:0] low_side_driver;
  } prc_drv_pins_t;

  typedef enum logic [0:0] {
    PRC_WRITE_OPEN,
    PRC_WRITE_LOCKED
  } prc_lock_t;

  typedef struct packed {
    logic [7:0] driver_pin_routing;
    prc_lock_t route_lock;
    logic [7:0] port_t_pull_polarity;
    logic [7:0] port_p_drive_strength;
    logic [7:0] port_p_pull_enable;
    logic [7:0] port_p_polarity;
    logic [7:0] port_p_irq_enable;
    logic [7:0] port_p_edge_flags;
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [5:0] pin_last;
    logic sync_valid;
    logic [31:0] prdata;
  } prc_state_t;

endpackage

// File: hw/prc_port_routing.sv
// Contract
// - routing readable always; normal mode write once
// - reset routing zero; pins follow port bits
// - bits 7-6 route second high-side pin
// - bits 5-4 route first high-side pin
// - bits 3-2 route second low-side pin
// - bits 1-0 route first low-side pin
// - port T polarity: 1 pulldown, 0 pullup
// - port P pull enable only for inputs
// - port P pull direction from polarity bit
// - reduced drive bit, outputs only
// - drive strength applies to any function
// - edge flag set on valid active edge
// - edge direction from polarity bit
// - interrupt when flag and enable set
// - flag 7 set on over-current
`timescale 1ns/1ns
`default_nettype none
`include "prc_params.svh"

module prc_port_routing
  import prc_pkg::*;
#(
  parameter int P_PINS = 6,
  parameter int T_PINS = 4
) (
  input wire logic clk_sys, // 250 mhz bus clock
  input wire logic rst, // synchronous, active high
  input wire logic special_mode, // 1 allows repeated routing writes
  input wire prc_apb_req_t apb_req, // apb request
  output prc_apb_rsp_t apb_rsp, // apb answer
  input wire logic [1:0] high_side_port_bits, // high-side driver port bits
  input wire logic [1:0] low_side_port_bits, // low-side driver port bits
  input wire logic [7:0] pwm_out, // pwm channel outputs
  input wire logic [7:0] pwm_enabled, // pwm channel enables
  input wire logic [3:0] timer_unit_oc, // timer compare outputs
  input wire logic [3:0] timer_unit_oc_en, // timer compare enables
  output prc_drv_pins_t drv_pins, // routed driver pin levels
  input wire logic [T_PINS-1:0] port_t_pull_on, // port t pull active
  output logic [T_PINS-1:0] port_t_pulldown, // port t pulldown on
  output logic [T_PINS-1:0] port_t_pullup, // port t pullup on
  input wire logic [P_PINS-1:0] port_p_in, // port p pin levels, async
  input wire logic [P_PINS-1:0] port_p_is_output, // port p direction
  output logic [P_PINS-1:0] port_p_pulldown, // port p pulldown on
  output logic [P_PINS-1:0] port_p_pullup, // port p pullup on
  output logic [P_PINS-1:0] port_p_reduced, // port p reduced drive
  input wire logic overcurrent_event, // protected_port_pin over-current pulse
  output logic irq // level interrupt
);

  // elaboration refuses pin counts that the register bytes cannot hold
  if (P_PINS < 1 || P_PINS > 6) begin : g_bad_p_pins
    $error("P_PINS must be 1..6");
  end
  if (T_PINS < 1 || T_PINS > 8) begin : g_bad_t_pins
    $error("T_PINS must be 1..8");
  end

  prc_state_t s;
  prc_state_t next_s;

  logic wr_acc;
  logic rd_acc;
  logic [P_PINS-1:0] rise;
  logic [P_PINS-1:0] fall;
  logic [7:0] edge_set;
  logic [7:0] wr_byte;

  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  assign wr_byte = apb_req.pwdata[7:0];

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < P_PINS; g++) begin : g_edge
      assign rise[g] = s.pin_sync[g] && !s.pin_last[g];
      assign fall[g] = !s.pin_sync[g] && s.pin_last[g];
      // polarity 1 picks rising, 0 falling
      assign edge_set[g] = s.sync_valid && (s.port_p_polarity[g] ? rise[g] : fall[g]);
    end
    for (g = P_PINS; g < 8; g++) begin : g_edge_pad
      assign edge_set[g] = 1'b0;
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] wdat;
    wdat = apb_req.pwdata[7:0];
    next_s = s;
    next_s.pin_meta = 6'(port_p_in);
    // first stage feeds only the second
    next_s.pin_sync = s.pin_meta;
    next_s.pin_last = s.pin_sync;
    next_s.sync_valid = 1'b1;
    next_s.prdata = 32'h0000_0000;
    if (rd_acc) begin
      if (apb_req.paddr == `PRC_ADDR_ROUTING) begin
        next_s.prdata = {24'h00_0000, s.driver_pin_routing};
      end else if (apb_req.paddr == `PRC_ADDR_T_POLARITY) begin
        next_s.prdata = {24'h00_0000, s.port_t_pull_polarity};
      end else if (apb_req.paddr == `PRC_ADDR_P_DRIVE) begin
        next_s.prdata = {24'h00_0000, s.port_p_drive_strength};
      end else if (apb_req.paddr == `PRC_ADDR_P_PULL_EN) begin
        next_s.prdata = {24'h00_0000, s.port_p_pull_enable};
      end else if (apb_req.paddr == `PRC_ADDR_P_FLAGS) begin
        next_s.prdata = {24'h00_0000, s.port_p_edge_flags};
      end else if (apb_req.paddr == `PRC_ADDR_P_POLARITY) begin
        next_s.prdata = {24'h00_0000, s.port_p_polarity};
      end else if (apb_req.paddr == `PRC_ADDR_P_IRQ_EN) begin
        next_s.prdata = {24'h00_0000, s.port_p_irq_enable};
      end
    end
    if (wr_acc) begin
      if (apb_req.paddr == `PRC_ADDR_ROUTING) begin
        // special mode writes also set the lock, so no write remains after leaving it
        if (special_mode || s.route_lock == PRC_WRITE_OPEN) begin
          next_s.driver_pin_routing = wdat;
          next_s.route_lock = PRC_WRITE_LOCKED;
        end
      end else if (apb_req.paddr == `PRC_ADDR_T_POLARITY) begin
        next_s.port_t_pull_polarity = wdat;
      end else if (apb_req.paddr == `PRC_ADDR_P_DRIVE) begin
        next_s.port_p_drive_strength = wdat;
      end else if (apb_req.paddr == `PRC_ADDR_P_PULL_EN) begin
        next_s.port_p_pull_enable = wdat & `PRC_EDGE_MASK;
      end else if (apb_req.paddr == `PRC_ADDR_P_FLAGS) begin
        next_s.port_p_edge_flags = s.port_p_edge_flags & ~wdat;
      end else if (apb_req.paddr == `PRC_ADDR_P_POLARITY) begin
        next_s.port_p_polarity = wdat;
      end else if (apb_req.paddr == `PRC_ADDR_P_IRQ_EN) begin
        next_s.port_p_irq_enable = wdat;
      end
    end
    // set wins over a same-cycle clear
    next_s.port_p_edge_flags = next_s.port_p_edge_flags | edge_set;
    if (overcurrent_event) begin
      next_s.port_p_edge_flags[`PRC_OC_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.driver_pin_routing <= `PRC_RST_ROUTING;
      s.route_lock <= PRC_WRITE_OPEN;
      s.port_p_edge_flags <= `PRC_RST_ZERO;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // apb answer: zero wait states, unmapped reads zero
  // ---------------------------------------------------------------
  assign apb_rsp = '{prdata: s.prdata, pready: 1'b1, pslverr: 1'b0};

  // ---------------------------------------------------------------
  // driver pin routing
  // ---------------------------------------------------------------
  logic [1:0] f_hsb;
  logic [1:0] f_hsa;
  logic [1:0] f_lsb;
  logic [1:0] f_lsa;
  assign f_hsb = s.driver_pin_routing[`PRC_HSB_LSB +: 2];
  assign f_hsa = s.driver_pin_routing[`PRC_HSA_LSB +: 2];
  assign f_lsb = s.driver_pin_routing[`PRC_LSB_LSB +: 2];
  assign f_lsa = s.driver_pin_routing[`PRC_LSA_LSB +: 2];

  // a routed source that is not enabled falls back to the port bit
  always_comb begin
    drv_pins.high_side_driver[1] = high_side_port_bits[1];
    if (f_hsb == `PRC_SEL_PWM && pwm_enabled[1]) begin
      drv_pins.high_side_driver[1] = pwm_out[1];
    end else if (f_hsb == `PRC_SEL_PWM_ALT && pwm_enabled[4]) begin
      drv_pins.high_side_driver[1] = pwm_out[4];
    end else if (f_hsb == `PRC_SEL_TIMER && timer_unit_oc_en[3]) begin
      drv_pins.high_side_driver[1] = timer_unit_oc[3];
    end
    drv_pins.high_side_driver[0] = high_side_port_bits[0];
    if (f_hsa[1] && pwm_enabled[3]) begin
      drv_pins.high_side_driver[0] = pwm_out[3];
    end else if (f_hsa == `PRC_SEL_TIMER && timer_unit_oc_en[2]) begin
      drv_pins.high_side_driver[0] = timer_unit_oc[2];
    end
    drv_pins.low_side_driver[1] = low_side_port_bits[1];
    if (f_lsb[1] && pwm_enabled[7]) begin
      drv_pins.low_side_driver[1] = pwm_out[7];
    end else if (f_lsb == `PRC_SEL_TIMER && timer_unit_oc_en[1]) begin
      drv_pins.low_side_driver[1] = timer_unit_oc[1];
    end
    drv_pins.low_side_driver[0] = low_side_port_bits[0];
    if (f_lsa == `PRC_SEL_PWM && pwm_enabled[5]) begin
      drv_pins.low_side_driver[0] = pwm_out[5];
    end else if (f_lsa == `PRC_SEL_PWM_ALT && pwm_enabled[6]) begin
      drv_pins.low_side_driver[0] = pwm_out[6];
    end else if (f_lsa == `PRC_SEL_TIMER && timer_unit_oc_en[0]) begin
      drv_pins.low_side_driver[0] = timer_unit_oc[0];
    end
  end

  // ---------------------------------------------------------------
  // pull devices and drive strength
  // ---------------------------------------------------------------
  assign port_t_pulldown = port_t_pull_on & s.port_t_pull_polarity[T_PINS-1:0];
  assign port_t_pullup = port_t_pull_on & ~s.port_t_pull_polarity[T_PINS-1:0];

  generate
    for (g = 0; g < P_PINS; g++) begin : g_pin
      logic pull_act;
      assign pull_act = s.port_p_pull_enable[g] && !port_p_is_output[g];
      assign port_p_pulldown[g] = pull_act && s.port_p_polarity[g];
      assign port_p_pullup[g] = pull_act && !s.port_p_polarity[g];
      // independent of what drives the pin
      assign port_p_reduced[g] = s.port_p_drive_strength[g] && port_p_is_output[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  assign irq = |(s.port_p_edge_flags & s.port_p_irq_enable);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence seq_locked_write;
    wr_acc && apb_req.paddr == `PRC_ADDR_ROUTING && !special_mode
      && s.route_lock == PRC_WRITE_LOCKED;
  endsequence

  AST_ROUTE_LOCK: assert property (@(posedge clk_sys) disable iff (rst)
    seq_locked_write |=> $stable(s.driver_pin_routing))
    else $error("routing changed after lock");

  AST_ROUTE_RESET: assert property (@(posedge clk_sys)
    $past(rst) |-> s.driver_pin_routing == 8'h00)
    else $error("routing not zero after reset");

  AST_HSB_PWM: assert property (@(posedge clk_sys) disable iff (rst)
    f_hsb == 2'h3 && pwm_enabled[1] |-> drv_pins.high_side_driver[1] == pwm_out[1])
    else $error("second high-side pin not from pwm 1");

  AST_HSA_TIMER: assert property (@(posedge clk_sys) disable iff (rst)
    f_hsa == 2'h1 && timer_unit_oc_en[2] |-> drv_pins.high_side_driver[0] == timer_unit_oc[2])
    else $error("first high-side pin not from timer 2");

  AST_LSB_PWM: assert property (@(posedge clk_sys) disable iff (rst)
    f_lsb[1] && pwm_enabled[7] |-> drv_pins.low_side_driver[1] == pwm_out[7])
    else $error("second low-side pin not from pwm 7");

  AST_LSA_PORT: assert property (@(posedge clk_sys) disable iff (rst)
    f_lsa == 2'h0 |-> drv_pins.low_side_driver[0] == low_side_port_bits[0])
    else $error("first low-side pin not from port bit");

  AST_T_PULL: assert property (@(posedge clk_sys) disable iff (rst)
    !(|(port_t_pulldown & port_t_pullup)))
    else $error("port t pull both ways");

  AST_P_PULL_OUT: assert property (@(posedge clk_sys) disable iff (rst)
    |(port_p_is_output & (port_p_pulldown | port_p_pullup)) == 1'b0)
    else $error("pull active on output");

  AST_EDGE_SET: assert property (@(posedge clk_sys) disable iff (rst)
    s.port_p_polarity[0] && $rose(port_p_in[0]) ##1 port_p_in[0] [*3]
      |-> s.port_p_edge_flags[0])
    else $error("rising edge not flagged");

  AST_OC_SET: assert property (@(posedge clk_sys) disable iff (rst)
    overcurrent_event |=> s.port_p_edge_flags[7])
    else $error("over-current flag not set");

  AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    s.port_p_edge_flags[0] && !(wr_acc && apb_req.paddr == `PRC_ADDR_P_FLAGS
      && apb_req.pwdata[0]) |=> s.port_p_edge_flags[0])
    else $error("flag dropped without write one");

  AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
    edge_set[0] && s.port_p_irq_enable[0] && !wr_acc |=> irq)
    else $error("enabled edge raised no interrupt");

  AST_ROUTE_OPEN: assert property (@(posedge clk_sys) disable iff (rst)
    wr_acc && apb_req.paddr == `PRC_ADDR_ROUTING
      && (special_mode || s.route_lock == PRC_WRITE_OPEN)
      |=> s.driver_pin_routing == $past(wr_byte))
    else $error("open routing write not taken");

  AST_ROUTE_READ: assert property (@(posedge clk_sys) disable iff (rst)
    rd_acc && apb_req.paddr == `PRC_ADDR_ROUTING
      |=> apb_rsp.prdata == {24'h00_0000, $past(s.driver_pin_routing)})
    else $error("routing read back wrong");

  AST_PRDATA_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    !rd_acc |=> apb_rsp.prdata == 32'h0000_0000)
    else $error("read data outside read access");

  AST_ROUTE_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    s.driver_pin_routing == 8'h00
      |-> drv_pins == {high_side_port_bits, low_side_port_bits})
    else $error("zero routing not from port bits");

  AST_HSB_ALT: assert property (@(posedge clk_sys) disable iff (rst)
    f_hsb == 2'h2 && pwm_enabled[4] |-> drv_pins.high_side_driver[1] == pwm_out[4])
    else $error("second high-side pin not from pwm 4");

  AST_HSB_TIMER: assert property (@(posedge clk_sys) disable iff (rst)
    f_hsb == 2'h1 && timer_unit_oc_en[3] |-> drv_pins.high_side_driver[1] == timer_unit_oc[3])
    else $error("second high-side pin not from timer 3");

  AST_HSB_FALLBACK: assert property (@(posedge clk_sys) disable iff (rst)
    f_hsb == 2'h3 && !pwm_enabled[1]
      |-> drv_pins.high_side_driver[1] == high_side_port_bits[1])
    else $error("disabled source did not fall back to port bit");

  AST_HSA_PWM: assert property (@(posedge clk_sys) disable iff (rst)
    f_hsa[1] && pwm_enabled[3] |-> drv_pins.high_side_driver[0] == pwm_out[3])
    else $error("first high-side pin not from pwm 3");

  AST_LSB_TIMER: assert property (@(posedge clk_sys) disable iff (rst)
    f_lsb == 2'h1 && timer_unit_oc_en[1] |-> drv_pins.low_side_driver[1] == timer_unit_oc[1])
    else $error("second low-side pin not from timer 1");

  AST_LSA_PWM: assert property (@(posedge clk_sys) disable iff (rst)
    f_lsa == 2'h3 && pwm_enabled[5] |-> drv_pins.low_side_driver[0] == pwm_out[5])
    else $error("first low-side pin not from pwm 5");

  AST_LSA_ALT: assert property (@(posedge clk_sys) disable iff (rst)
    f_lsa == 2'h2 && pwm_enabled[6] |-> drv_pins.low_side_driver[0] == pwm_out[6])
    else $error("first low-side pin not from pwm 6");

  AST_LSA_TIMER: assert property (@(posedge clk_sys) disable iff (rst)
    f_lsa == 2'h1 && timer_unit_oc_en[0] |-> drv_pins.low_side_driver[0] == timer_unit_oc[0])
    else $error("first low-side pin not from timer 0");

  AST_T_PULLDOWN: assert property (@(posedge clk_sys) disable iff (rst)
    port_t_pull_on[0] && s.port_t_pull_polarity[0] |-> port_t_pulldown[0])
    else $error("port t pulldown missing");

  AST_T_PULLUP: assert property (@(posedge clk_sys) disable iff (rst)
    port_t_pull_on[0] && !s.port_t_pull_polarity[0] |-> port_t_pullup[0])
    else $error("port t pullup missing");

  AST_P_PULLDOWN: assert property (@(posedge clk_sys) disable iff (rst)
    s.port_p_pull_enable[0] && !port_p_is_output[0] && s.port_p_polarity[0]
      |-> port_p_pulldown[0])
    else $error("port p pulldown missing");

  AST_P_PULLUP: assert property (@(posedge clk_sys) disable iff (rst)
    s.port_p_pull_enable[0] && !port_p_is_output[0] && !s.port_p_polarity[0]
      |-> port_p_pullup[0])
    else $error("port p pullup missing");

  AST_REDUCED_IN: assert property (@(posedge clk_sys) disable iff (rst)
    |(port_p_reduced & ~port_p_is_output) == 1'b0)
    else $error("reduced drive on input");

  AST_REDUCED_OUT: assert property (@(posedge clk_sys) disable iff (rst)
    port_p_is_output[0] && s.port_p_drive_strength[0] |-> port_p_reduced[0])
    else $error("reduced drive missing on output");

  AST_EDGE_FALL: assert property (@(posedge clk_sys) disable iff (rst)
    !s.port_p_polarity[P_PINS-1] && $fell(port_p_in[P_PINS-1]) ##1 !port_p_in[P_PINS-1] [*3]
      |-> s.port_p_edge_flags[P_PINS-1])
    else $error("falling edge not flagged");

  sequence seq_pin0_quiet_rise;
    !port_p_in[0] [*3] ##1 port_p_in[0];
  endsequence

  AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (rst)
    seq_pin0_quiet_rise ##0 !s.port_p_edge_flags[0]
      |=> !s.port_p_edge_flags[0] ##1 !s.port_p_edge_flags[0])
    else $error("edge flagged before synchroniser delay");

  AST_FLAG_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    wr_acc && apb_req.paddr == `PRC_ADDR_P_FLAGS && wr_byte[0] && !edge_set[0]
      |=> !s.port_p_edge_flags[0])
    else $error("flag not cleared by write one");

  AST_OC_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    s.port_p_edge_flags[`PRC_OC_BIT] && !(wr_acc && apb_req.paddr == `PRC_ADDR_P_FLAGS
      && wr_byte[`PRC_OC_BIT]) |=> s.port_p_edge_flags[`PRC_OC_BIT])
    else $error("over-current flag dropped without write one");

endmodule
`default_nettype wire
